// File: bipfs_pkg.sv
// package: constants of the binary input pulse frequency scaler
package bipfs_pkg;
	// clock and gate timing
	localparam int unsigned CLK_HZ   = 20_000_000;
	localparam int unsigned GATE_MS  = 1000;
	localparam int unsigned GATE_CYC = GATE_MS * (CLK_HZ / 1000);

	// register indices on the 4-bit address port
	localparam logic [3:0] A_CTRL  = 4'h0;
	localparam logic [3:0] A_MAXF  = 4'h1;
	localparam logic [3:0] A_LRV   = 4'h2;
	localparam logic [3:0] A_URV   = 4'h3;
	localparam logic [3:0] A_DAMP  = 4'h4;
	localparam logic [3:0] A_STAT  = 4'h5;
	localparam logic [3:0] A_FREQ  = 4'h6;
	localparam logic [3:0] A_VALUE = 4'h7;
	localparam logic [3:0] A_NAME0 = 4'h8;
	localparam logic [3:0] A_UNIT0 = 4'hC;

	// control register fields
	localparam int unsigned C_EN     = 0;
	localparam int unsigned C_PFM    = 1;
	localparam int unsigned C_ACTHI  = 2;
	localparam int unsigned C_VAR_LO = 3;
	localparam int unsigned C_DEC_LO = 5;

	// status register fields
	localparam int unsigned S_ACTIVE = 0;
	localparam int unsigned S_OVR    = 1;
	localparam int unsigned S_VALID  = 2;

	// values after reset
	localparam logic       EN_RST    = 1'h1;
	localparam logic       PFM_RST   = 1'h0;
	localparam logic       ACTHI_RST = 1'h1;
	localparam logic [1:0] VAR_RST   = 2'h0;
	localparam logic [2:0] DEC_RST   = 3'h2;
	localparam logic [5:0] DAMP_RST  = 6'h00;

	// limits in hundredths (centi-Hz, centi-units), damping limit in seconds
	localparam logic [31:0] MAXF_MIN = 32'h00002710;
	localparam logic [31:0] MAXF_MAX = 32'h000186A0;
	localparam logic [31:0] MAXF_RST = 32'h000186A0;
	localparam logic [31:0] LRV_MIN  = 32'hFFFCF2C0;
	localparam logic [31:0] LRV_RST  = 32'h00000000;
	localparam logic [31:0] URV_MAX  = 32'h000F4240;
	localparam logic [31:0] URV_RST  = 32'h00000000;
	localparam logic [5:0]  DAMP_MAX = 6'h3C;
	localparam logic [31:0] CENTI    = 32'h00000064;

	// input variable encodings
	localparam logic [1:0] VAR_FREQ  = 2'h0;
	localparam logic [1:0] VAR_PARAM = 2'h1;
	localparam logic [1:0] VAR_FLOW  = 2'h2;

	// divider length
	localparam logic [5:0] DIV_STEPS = 6'h28;
endpackage

// File: bipfs_hist_mem.sv
// sample history memory for the floating average
`timescale 1ns/10ps
module bipfs_hist_mem #(
	parameter int DW = 32,
	parameter int AW = 6
) (
	// clock
	input  wire logic          i_clk,
	input  wire logic          i_reset_n,
	input  wire logic          i_ce,
	// write port
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	// read port, data one cycle later
	input  wire logic          i_re,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rdata_q;

	// storage; a read at the written address returns the old word
	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// registered read port
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q <= '0;
		end else if (i_ce && i_re) begin
			rdata_q <= mem[i_raddr];
		end
	end

	assign o_rdata = rdata_q;
endmodule

// File: bipfs_channel.sv
// binary input channel: static level and pulse frequency scaler
`timescale 1ns/10ps
// What this block does
// - channel enable off/on, default on; disabled channel yields no new results, o_freq and o_value hold their last values
// - signal type static level or pulse frequency, static after reset
// - static mode: low or high level is active, high by default
// - static active state only goes out on o_active and status bit 0
// - maximum frequency 100.00 to 1000.00 Hz, default 1000.00, full scale
// - frequencies above the maximum are not taken as valid measurements
// - result shown as frequency, user parameter or flow rate, default Hz
// - user parameter name and unit, sixteen characters each, stored
// - lower range value -2000.00..0.00, default 0, output at 0 Hz
// - upper range value 0.00..10000.00, default 0, output at maximum
// - floating average over 0 to 60 seconds, default zero
// - number of decimal places of the value is configurable
module bipfs_channel #(
	parameter int unsigned GATE_CYC = bipfs_pkg::GATE_CYC,
	parameter int          HIST_AW  = 6
) (
	// clock, reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_ce,
	// binary input pin
	input  wire logic        i_bin,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// static level result
	output logic             o_active,
	// pulse frequency result
	output logic      [31:0] o_freq,
	output logic      [31:0] o_value,
	output logic             o_value_stb,
	output logic             o_valid,
	output logic             o_overrange,
	// presentation settings
	output logic      [1:0]  o_var_sel,
	output logic      [2:0]  o_decimals
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_UPD,
		ST_DIV,
		ST_OUT
	} bipfs_fsm_t;

	typedef struct packed {
		logic             en;
		logic             pfm;
		logic             act_hi;
		logic [1:0]       var_sel;
		logic [2:0]       dec;
		logic [31:0]      maxf;
		logic [31:0]      lrv;
		logic [31:0]      urv;
		logic [5:0]       damp;
		logic [7:0][31:0] text;
		logic [31:0]      rdata;
		logic             in_q;
		logic             active;
		logic             ovr;
		logic             valid;
		logic             stb;
		logic [31:0]      gate;
		logic [31:0]      pcnt;
		logic [31:0]      freq;
		logic [31:0]      value;
		bipfs_fsm_t       st;
		logic             ph;
		logic [5:0]       idx;
		logic [5:0]       n;
		logic [31:0]      sum;
		logic [39:0]      dn;
		logic [31:0]      dd;
		logic [32:0]      dr;
		logic [5:0]       dc;
	} bipfs_state_t;

	bipfs_state_t q;
	bipfs_state_t d;

	logic [31:0]        hist_rdata;
	logic               hist_we;
	logic               hist_re;
	logic [HIST_AW-1:0] hist_addr;
	logic [31:0]        span;
	logic [32:0]        trial;

	// history of frequency samples, one word per gate period
	bipfs_hist_mem #(
		.DW (32),
		.AW (HIST_AW)
	) u_hist (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_ce      (i_ce),
		.i_we      (hist_we),
		.i_waddr   (hist_addr),
		.i_wdata   (q.freq),
		.i_re      (hist_re),
		.i_raddr   (hist_addr),
		.o_rdata   (hist_rdata)
	);

	// memory strobes follow the averaging sequence
	assign hist_re   = (q.st == ST_READ);
	assign hist_we   = (q.st == ST_UPD);
	assign hist_addr = q.idx[HIST_AW-1:0];

	// span never negative since upper >= 0 >= lower
	assign span  = q.urv - q.lrv;
	assign trial = {q.dr[31:0], q.dn[39]};

	// next-state logic: register port, level path, gate, averaging, scaling
	always_comb begin
		d     = q;
		d.stb = 1'b0;
		d.in_q = i_bin;

		// register writes; maximum frequency, range values and damping clamped to their legal ranges, control and text stored as written
		if (i_wr) begin
			case (i_addr)
				bipfs_pkg::A_CTRL: begin
					d.en      = i_wdata[bipfs_pkg::C_EN];
					d.pfm     = i_wdata[bipfs_pkg::C_PFM];
					d.act_hi  = i_wdata[bipfs_pkg::C_ACTHI];
					d.var_sel = i_wdata[bipfs_pkg::C_VAR_LO +: 2];
					d.dec     = i_wdata[bipfs_pkg::C_DEC_LO +: 3];
				end
				bipfs_pkg::A_MAXF: begin
					if (i_wdata < bipfs_pkg::MAXF_MIN) begin
						d.maxf = bipfs_pkg::MAXF_MIN;
					end else if (i_wdata > bipfs_pkg::MAXF_MAX) begin
						d.maxf = bipfs_pkg::MAXF_MAX;
					end else begin
						d.maxf = i_wdata;
					end
				end
				bipfs_pkg::A_LRV: begin
					if ($signed(i_wdata) < $signed(bipfs_pkg::LRV_MIN)) begin
						d.lrv = bipfs_pkg::LRV_MIN;
					end else if ($signed(i_wdata) > 0) begin
						d.lrv = '0;
					end else begin
						d.lrv = i_wdata;
					end
				end
				bipfs_pkg::A_URV: begin
					if ($signed(i_wdata) < 0) begin
						d.urv = '0;
					end else if (i_wdata > bipfs_pkg::URV_MAX) begin
						d.urv = bipfs_pkg::URV_MAX;
					end else begin
						d.urv = i_wdata;
					end
				end
				bipfs_pkg::A_DAMP: begin
					if (i_wdata > 32'(bipfs_pkg::DAMP_MAX)) begin
						d.damp = bipfs_pkg::DAMP_MAX;
					end else begin
						d.damp = i_wdata[5:0];
					end
					// a new window restarts the average from empty
					d.n   = '0;
					d.idx = '0;
					d.sum = '0;
				end
				default: begin
					if (i_addr[3]) begin
						d.text[i_addr[2:0]] = i_wdata;
					end
				end
			endcase
		end

		// register reads, data stand from the next cycle until the next read
		if (i_rd) begin
			case (i_addr)
				bipfs_pkg::A_CTRL: begin
					d.rdata = {24'h000000, q.dec, q.var_sel, q.act_hi,
						q.pfm, q.en};
				end
				bipfs_pkg::A_MAXF:  d.rdata = q.maxf;
				bipfs_pkg::A_LRV:   d.rdata = q.lrv;
				bipfs_pkg::A_URV:   d.rdata = q.urv;
				bipfs_pkg::A_DAMP:  d.rdata = {26'h0000000, q.damp};
				bipfs_pkg::A_STAT: begin
					d.rdata = {29'h00000000, q.valid, q.ovr, q.active};
				end
				bipfs_pkg::A_FREQ:  d.rdata = q.freq;
				bipfs_pkg::A_VALUE: d.rdata = q.value;
				default:            d.rdata = q.text[i_addr[2:0]];
			endcase
		end

		// static level: active when the pin matches the chosen level
		d.active = q.en && !q.pfm && (i_bin == q.act_hi);

		// pulse counting over a fixed gate; count saturates, never wraps
		if (q.en && q.pfm) begin
			if (i_bin && !q.in_q && q.pcnt != 32'hFFFFFFFF) begin
				d.pcnt = q.pcnt + 32'h00000001;
			end
			if (q.gate == 32'(GATE_CYC - 1)) begin
				d.gate = '0;
				d.pcnt = '0;
				d.freq = 32'(q.pcnt * bipfs_pkg::CENTI);
				// a new sample arriving while another is in flight is dropped, not queued
				if (q.st == ST_IDLE) begin
					d.st = ST_READ;
				end
			end else begin
				d.gate = q.gate + 32'h00000001;
			end
		end else begin
			d.gate = '0;
			d.pcnt = '0;
		end

		// averaging and scaling sequence, shared restoring divider
		case (q.st)
			ST_IDLE: begin
			end
			ST_READ: begin
				if (q.freq > q.maxf) begin
					d.ovr = 1'b1;
					d.st  = ST_IDLE;
				end else begin
					d.ovr = 1'b0;
					if (q.damp == '0) begin
						// no window: scale the fresh sample directly
						d.ph = 1'b1;
						d.dn = 40'(span) * 40'(q.freq);
						d.dd = q.maxf;
						d.dr = '0;
						d.dc = '0;
						d.st = ST_DIV;
					end else begin
						d.st = ST_UPD;
					end
				end
			end
			ST_UPD: begin
				// oldest sample leaves once the window is full
				if (q.n >= q.damp) begin
					d.sum = q.sum + q.freq - hist_rdata;
				end else begin
					d.sum = q.sum + q.freq;
					d.n   = q.n + 6'h01;
				end
				if (q.idx + 6'h01 >= q.damp) begin
					d.idx = '0;
				end else begin
					d.idx = q.idx + 6'h01;
				end
				d.ph = 1'b0;
				d.dn = 40'(d.sum);
				d.dd = 32'(d.n);
				d.dr = '0;
				d.dc = '0;
				d.st = ST_DIV;
			end
			ST_DIV: begin
				if (q.dc == bipfs_pkg::DIV_STEPS) begin
					if (!q.ph) begin
						// average done, now scale it
						d.ph = 1'b1;
						d.dn = 40'(span) * 40'(q.dn[31:0]);
						d.dd = q.maxf;
						d.dr = '0;
						d.dc = '0;
					end else begin
						d.st = ST_OUT;
					end
				end else begin
					if (trial >= {1'b0, q.dd}) begin
						d.dr = trial - {1'b0, q.dd};
						d.dn = {q.dn[38:0], 1'b1};
					end else begin
						d.dr = trial;
						d.dn = {q.dn[38:0], 1'b0};
					end
					d.dc = q.dc + 6'h01;
				end
			end
			ST_OUT: begin
				d.value = q.lrv + q.dn[31:0];
				d.valid = 1'b1;
				d.stb   = 1'b1;
				d.st    = ST_IDLE;
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// a disabled or static channel delivers no frequency results
		if (!q.en || !q.pfm) begin
			d.st    = ST_IDLE;
			d.valid = 1'b0;
			d.ovr   = 1'b0;
			d.stb   = 1'b0;
			d.n     = '0;
			d.idx   = '0;
			d.sum   = '0;
		end
	end

	// state register; the clock enable freezes everything
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q         <= '0;
			q.en      <= bipfs_pkg::EN_RST;
			q.pfm     <= bipfs_pkg::PFM_RST;
			q.act_hi  <= bipfs_pkg::ACTHI_RST;
			q.var_sel <= bipfs_pkg::VAR_RST;
			q.dec     <= bipfs_pkg::DEC_RST;
			q.maxf    <= bipfs_pkg::MAXF_RST;
			q.lrv     <= bipfs_pkg::LRV_RST;
			q.urv     <= bipfs_pkg::URV_RST;
			q.damp    <= bipfs_pkg::DAMP_RST;
			q.st      <= ST_IDLE;
		end else if (i_ce) begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign o_rdata     = q.rdata;
	assign o_active    = q.active;
	assign o_freq      = q.freq;
	assign o_value     = q.value;
	assign o_value_stb = q.stb;
	assign o_valid     = q.valid;
	assign o_overrange = q.ovr;
	assign o_var_sel   = q.var_sel;
	assign o_decimals  = q.dec;
endmodule

// File: bipfs_channel_asserts.sv
// checker: port relations of the binary input channel
`timescale 1ns/10ps
module bipfs_channel_asserts (
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	// register port
	input wire logic [3:0]  i_addr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	// results
	input wire logic        o_active,
	input wire logic [31:0] o_freq,
	input wire logic [31:0] o_value,
	input wire logic        o_value_stb,
	input wire logic        o_valid,
	input wire logic        o_overrange,
	input wire logic [1:0]  o_var_sel,
	input wire logic [2:0]  o_decimals
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// read data hold until the next read
	a_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata))
		else $error("read data moved without a read");
	a_stb_single: assert property (o_value_stb |=> !o_value_stb)
		else $error("value strobe longer than one cycle");
	a_stb_valid: assert property (o_value_stb |-> o_valid)
		else $error("value strobe without valid");
	a_value_stb: assert property (
		(o_value != $past(o_value)) |-> o_value_stb)
		else $error("value changed without strobe");
	a_stb_no_ovr: assert property (o_value_stb |-> !o_overrange)
		else $error("value produced from an overrange sample");
	// control read mirrors the presentation outputs
	a_ctrl_mirror: assert property (
		$past(i_rd && i_addr == bipfs_pkg::A_CTRL)
		|-> o_rdata[4:3] == o_var_sel && o_rdata[7:5] == o_decimals)
		else $error("control read differs from outputs");
	a_status_mirror: assert property (
		$past(i_rd && i_addr == bipfs_pkg::A_STAT)
		|-> o_rdata[2:0] == {$past(o_valid), $past(o_overrange), $past(o_active)})
		else $error("status read differs from outputs");
	a_freq_mirror: assert property (
		$past(i_rd && i_addr == bipfs_pkg::A_FREQ)
		|-> o_rdata == $past(o_freq))
		else $error("frequency read differs from output");
	a_value_mirror: assert property (
		$past(i_rd && i_addr == bipfs_pkg::A_VALUE)
		|-> o_rdata == $past(o_value))
		else $error("value read differs from output");

	// main scenarios reached
	c_value: cover property (o_value_stb);
	c_ovr: cover property (o_overrange);
	c_active: cover property ($rose(o_active));
endmodule

bind bipfs_channel bipfs_channel_asserts u_chk (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_active(o_active), .o_freq(o_freq), .o_value(o_value),
	.o_value_stb(o_value_stb), .o_valid(o_valid),
	.o_overrange(o_overrange), .o_var_sel(o_var_sel),
	.o_decimals(o_decimals));

// File: bipfs_pulse_src.sv
// far side model: flowmeter pulse train, steady low while stopped
`timescale 1ns/10ps
module bipfs_pulse_src (
	// clock
	input  wire logic       i_clk,
	// pulse control
	input  wire logic       i_run,
	input  wire logic [7:0] i_half,
	// output to the channel pin
	output logic            o_pulse
);
	logic [7:0] cnt_q;
	// square wave; idle low like a pulled-down open collector
	always_ff @(posedge i_clk) begin
		if (!i_run) begin
			cnt_q   <= 8'h00;
			o_pulse <= 1'b0;
		end else if (cnt_q >= i_half - 8'h01) begin
			cnt_q   <= 8'h00;
			o_pulse <= ~o_pulse;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// File: tb_binary_input_pulse_freq_scaler.sv
// testbench of the binary input channel
`timescale 1ns/10ps
module tb_binary_input_pulse_freq_scaler;
	localparam int unsigned GATE = 400; // short gate keeps the run brief
	logic clk = 1'b0, rst_n = 1'b0, lvl = 1'b0, use_src = 1'b0;
	logic wr = 1'b0, rd = 1'b0, run = 1'b0, ce = 1'b1, pulse;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h00000000, rdata, value, freq, d;
	logic [7:0] half = 8'h05;
	logic active, stb, valid, ovr;
	logic [1:0] var_sel;
	logic [2:0] decimals;
	int n_errors = 0, checks = 0;

	always #25 clk = ~clk;

	bipfs_pulse_src u_src (.i_clk(clk), .i_run(run), .i_half(half),
		.o_pulse(pulse));
	bipfs_channel #(.GATE_CYC(GATE), .HIST_AW(6)) u_dut (.i_clk(clk),
		.i_reset_n(rst_n), .i_ce(ce), .i_bin(use_src ? pulse : lvl),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_active(active), .o_freq(freq), .o_value(value),
		.o_value_stb(stb), .o_valid(valid), .o_overrange(ovr),
		.o_var_sel(var_sel), .o_decimals(decimals));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// register bus cycles
	task automatic wrr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdr(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// bounded wait for a value strobe
	task automatic wait_stb;
		int i;
		for (i = 0; i < 3000 && stb !== 1'b1; i++)
			@(posedge clk) #1;
		if (stb !== 1'b1) begin
			n_errors++;
			final_report();
		end
		// step past this strobe so a following wait needs a fresh one
		@(posedge clk) #1;
	endtask

	task automatic t_reset_regs;
		chk(decimals, 32'h2);
		chk(var_sel, bipfs_pkg::VAR_FREQ);
		rdr(bipfs_pkg::A_CTRL, d); chk(d, 32'h00000045);
		rdr(bipfs_pkg::A_MAXF, d); chk(d, bipfs_pkg::MAXF_RST);
		rdr(bipfs_pkg::A_LRV, d); chk(d, bipfs_pkg::LRV_RST);
		rdr(bipfs_pkg::A_URV, d); chk(d, bipfs_pkg::URV_RST);
		rdr(bipfs_pkg::A_DAMP, d); chk(d, 32'h00000000);
	endtask

	task automatic t_limits_text;
		wrr(bipfs_pkg::A_MAXF, 32'h00000000);
		rdr(bipfs_pkg::A_MAXF, d); chk(d, bipfs_pkg::MAXF_MIN);
		wrr(bipfs_pkg::A_DAMP, 32'h000000FF);
		rdr(bipfs_pkg::A_DAMP, d); chk(d, 32'h0000003C);
		wrr(bipfs_pkg::A_LRV, 32'h80000000);
		rdr(bipfs_pkg::A_LRV, d); chk(d, bipfs_pkg::LRV_MIN);
		wrr(bipfs_pkg::A_DAMP, 32'h00000000);
		wrr(bipfs_pkg::A_NAME0 + 4'h3, 32'h41424344);
		wrr(bipfs_pkg::A_UNIT0 + 4'h3, 32'h61626364);
		rdr(bipfs_pkg::A_NAME0 + 4'h3, d); chk(d, 32'h41424344);
		rdr(bipfs_pkg::A_UNIT0 + 4'h3, d); chk(d, 32'h61626364);
	endtask

	task automatic t_static;
		@(posedge clk) lvl <= 1'b1;
		repeat (3) @(posedge clk);
		chk(active, 1'b1);
		// a low clock enable freezes the level result
		ce <= 1'b0;
		lvl <= 1'b0;
		repeat (3) @(posedge clk);
		chk(active, 1'b1);
		ce <= 1'b1;
		lvl <= 1'b1;
		repeat (2) @(posedge clk);
		wrr(bipfs_pkg::A_CTRL, 32'h00000041);
		repeat (2) @(posedge clk);
		chk(active, 1'b0);
		lvl <= 1'b0;
		repeat (3) @(posedge clk);
		chk(active, 1'b1);
		rdr(bipfs_pkg::A_STAT, d); chk(d[0], 1'b1);
		wrr(bipfs_pkg::A_CTRL, 32'h00000040);
		repeat (2) @(posedge clk);
		chk(active, 1'b0);
	endtask

	task automatic t_pfm;
		wrr(bipfs_pkg::A_LRV, 32'hFFFFFC18);
		wrr(bipfs_pkg::A_URV, 32'h00002710);
		wrr(bipfs_pkg::A_CTRL, 32'h0000004F);
		use_src <= 1'b1;
		run <= 1'b1;
		wait_stb();
		wait_stb();
		chk(freq, 32'h00000FA0);
		chk(value, 32'h00000D48);
		chk(valid, 1'b1);
		chk(var_sel, bipfs_pkg::VAR_PARAM);
		rdr(bipfs_pkg::A_VALUE, d); chk(d, 32'h00000D48);
		rdr(bipfs_pkg::A_FREQ, d); chk(d, 32'h00000FA0);
	endtask

	task automatic t_over;
		int i;
		half <= 8'h01;
		for (i = 0; i < 3000 && ovr !== 1'b1; i++)
			@(posedge clk) #1;
		if (ovr !== 1'b1) begin
			n_errors++;
			final_report();
		end
		repeat (GATE + 100) @(posedge clk);
		chk(ovr, 1'b1);
		chk(value, 32'h00000D48);
		chk(freq, 32'h00004E20);
		wrr(bipfs_pkg::A_CTRL, 32'h0000004E);
		repeat (2) @(posedge clk);
		chk(valid, 1'b0);
	endtask

	// two-sample window: 4000, 4000, then a cut gate of 900, then zeros
	task automatic t_damp;
		run <= 1'b0;
		half <= 8'h05;
		wrr(bipfs_pkg::A_DAMP, 32'h00000002);
		wrr(bipfs_pkg::A_CTRL, 32'h00000077);
		run <= 1'b1;
		wait_stb();
		wait_stb();
		chk(decimals, 32'h3);
		chk(var_sel, bipfs_pkg::VAR_FLOW);
		chk(value, 32'h00000D48);
		run <= 1'b0;
		wait_stb();
		chk(value, 32'h0000069F);
		wait_stb();
		chk(value, 32'hFFFFFE07);
		wait_stb();
		chk(value, 32'hFFFFFC18);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset_regs();
		t_limits_text();
		t_static();
		t_pfm();
		t_over();
		t_damp();
		final_report();
	end
endmodule
